// ### hdl/dual_supply_pkg.sv
// constants and types for the two-wire control target of a dual supply
// assumes a single 100 MHz clock domain; no imports anywhere
package dual_supply_pkg;

  // register addresses seen on the bus
  localparam logic [7:0] ADDR_STATUS1   = 8'h00;
  localparam logic [7:0] ADDR_STATUS2   = 8'h01;
  localparam logic [7:0] ADDR_VOLT_SEL  = 8'h02;
  localparam logic [7:0] ADDR_TONE_MODE = 8'h03;

  // reset values of the two control registers
  localparam logic [7:0] VOLT_SEL_RST   = 8'h00;
  localparam logic [7:0] TONE_MODE_RST  = 8'h00;
  // answer for addresses that hold nothing here
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  // field positions in the voltage select register
  localparam int VSEL_A_LSB      = 0;
  localparam int VSEL_B_LSB      = 4;
  localparam int VSEL_W          = 4;

  // field positions in the tone and mode register
  localparam int TONE_ON_A_BIT   = 0;
  localparam int LOW_POWER_A_BIT = 1;
  localparam int KIND_A_BIT      = 2;
  localparam int TONE_ON_B_BIT   = 4;
  localparam int LOW_POWER_B_BIT = 5;
  localparam int KIND_B_BIT      = 6;

  // byte framing
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic       DIR_READ    = 1'b1;

  // protocol engine states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RX     = 3'b001,
    ST_ACK    = 3'b010,
    ST_TX     = 3'b011,
    ST_MACK   = 3'b100,
    ST_IGNORE = 3'b101
  } state_t;

  // which byte of a transfer is being received
  typedef enum logic [1:0] {
    PH_CHIP = 2'b00,
    PH_REG  = 2'b01,
    PH_DATA = 2'b10
  } phase_t;

endpackage

// ### hdl/bus_events_if.sv
// events of the two-wire bus lines, passed from the line watcher
// assumes producer and consumer share one clock
`timescale 1ns/100ps
interface bus_events_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;

  // watcher produces, protocol engine consumes
  modport watch (output scl_rise, output scl_fall, output start,
                 output stop, output sda);
  modport use_ev (input scl_rise, input scl_fall, input start,
                  input stop, input sda);
endinterface

// ### hdl/bus_line_watch.sv
// synchronises the clock and data pins and flags edges, start and stop
// assumes pins are asynchronous to clk_i; ce_i low freezes everything
`timescale 1ns/100ps
module bus_line_watch (
  input  wire logic    clk_i,
  input  wire logic    rst_i,
  input  wire logic    ce_i,
  input  wire logic    scl_i,
  input  wire logic    sda_i,
  bus_events_if.watch  ev
);

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_p;
    logic sda_s1;
    logic sda_s2;
    logic sda_p;
  } watch_t;

  watch_t r_reg;
  watch_t r_next;

  // two-stage synchronisers, then one stage of history
  always_comb begin
    r_next        = r_reg;
    r_next.scl_s1 = scl_i;
    r_next.scl_s2 = r_reg.scl_s1;
    r_next.scl_p  = r_reg.scl_s2;
    r_next.sda_s1 = sda_i;
    r_next.sda_s2 = r_reg.sda_s1;
    r_next.sda_p  = r_reg.sda_s2;
  end

  // idle bus is high on both lines
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg <= '1;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  // edges and conditions from synchronised history only
  assign ev.scl_rise = r_reg.scl_s2 & ~r_reg.scl_p;
  assign ev.scl_fall = ~r_reg.scl_s2 & r_reg.scl_p;
  assign ev.start = r_reg.scl_s2 & r_reg.scl_p
                    & r_reg.sda_p & ~r_reg.sda_s2;
  assign ev.stop  = r_reg.scl_s2 & r_reg.scl_p
                    & ~r_reg.sda_p & r_reg.sda_s2;
  assign ev.sda   = r_reg.sda_s2;

endmodule // bus_line_watch

// ### hdl/dual_supply_ctrl.sv
// two-wire target with the voltage select and tone/mode registers
// assumes clk_i far faster than the bus clock; bus pins asynchronous
`timescale 1ns/100ps
module dual_supply_ctrl (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic [6:0] chip_addr_i,
  input  wire logic       uvlo_i,
  input  wire logic       tone_input_pin_a_i,
  input  wire logic       tone_input_pin_b_i,
  input  wire logic [7:0] status1_i,
  input  wire logic [7:0] status2_i,
  output logic [3:0]      volt_sel_a_o,
  output logic [3:0]      volt_sel_b_o,
  output logic            tone_gate_a_o,
  output logic            tone_gate_b_o,
  output logic            low_power_a_o,
  output logic            low_power_b_o,
  output logic            tone_input_kind_a_o,
  output logic            tone_input_kind_b_o,
  output logic            busy_o
);

  // whole state of the block
  typedef struct packed {
    dual_supply_pkg::state_t st;
    dual_supply_pkg::phase_t phase;
    logic [3:0]              bitcnt;
    logic [7:0]              shift;
    logic [7:0]              ptr;
    logic                    rd;
    logic                    mack_high;
    logic                    sda_oe;
    logic                    busy;
    logic [7:0]              volt_sel;
    logic [7:0]              tone_mode;
    logic [1:0]              tone_gate;
    logic [1:0]              low_power;
    logic [6:0]              chip_s1;
    logic [6:0]              chip_s2;
    logic                    uvlo_s1;
    logic                    uvlo_s2;
    logic [1:0]              tin_s1;
    logic [1:0]              tin_s2;
  } ctl_t;

  localparam ctl_t CTL_RST = '{
    st:        dual_supply_pkg::ST_IDLE,
    phase:     dual_supply_pkg::PH_CHIP,
    bitcnt:    4'h0,
    shift:     8'h00,
    ptr:       8'h00,
    rd:        1'b0,
    mack_high: 1'b0,
    sda_oe:    1'b0,
    busy:      1'b0,
    volt_sel:  dual_supply_pkg::VOLT_SEL_RST,
    tone_mode: dual_supply_pkg::TONE_MODE_RST,
    tone_gate: 2'h0,
    low_power: 2'h0,
    chip_s1:   7'h00,
    chip_s2:   7'h00,
    uvlo_s1:   1'b1,
    uvlo_s2:   1'b1,
    tin_s1:    2'h0,
    tin_s2:    2'h0
  };

  ctl_t r_reg;
  ctl_t r_next;

  bus_events_if ev ();

  // line synchronisers and event detection
  bus_line_watch u_watch (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .scl_i (scl_i),
    .sda_i (sda_i),
    .ev    (ev.watch)
  );

  // byte returned for a register address
  function automatic logic [7:0] read_byte(
    input logic [7:0] addr,
    input logic [7:0] vsel,
    input logic [7:0] tmode
  );
    logic [7:0] v;
    v = dual_supply_pkg::UNMAPPED_READ;
    case (addr)
      dual_supply_pkg::ADDR_STATUS1:   v = status1_i;
      dual_supply_pkg::ADDR_STATUS2:   v = status2_i;
      dual_supply_pkg::ADDR_VOLT_SEL:  v = vsel;
      dual_supply_pkg::ADDR_TONE_MODE: v = tmode;
      default:                         v = dual_supply_pkg::UNMAPPED_READ;
    endcase
    return v;
  endfunction

  // pointer after one byte, wrapping from 8'hff to 8'h00 rather than at the top of the map
  function automatic logic [7:0] next_ptr(input logic [7:0] p);
    return p + 8'h01;
  endfunction

  // tone passes to the supply only while its channel is enabled
  function automatic logic tone_gated(input logic en, input logic pin);
    return en & pin;
  endfunction

  // low power request dropped while the tone is enabled,
  // so a careless write can never starve a tone in progress
  function automatic logic low_power_gated(input logic lp, input logic en);
    return lp & ~en;
  endfunction

  // next state of the protocol engine and registers
  always_comb begin
    r_next = r_reg;

    // pin synchronisers: first stage read only by second
    r_next.chip_s1 = chip_addr_i;
    r_next.chip_s2 = r_reg.chip_s1;
    r_next.uvlo_s1 = uvlo_i;
    r_next.uvlo_s2 = r_reg.uvlo_s1;
    r_next.tin_s1  = {tone_input_pin_b_i, tone_input_pin_a_i};
    r_next.tin_s2  = r_reg.tin_s1;

    case (r_reg.st)
      dual_supply_pkg::ST_IDLE: begin
        r_next.sda_oe = 1'b0;
      end

      // receive eight bits, sampled while the clock is high
      dual_supply_pkg::ST_RX: begin
        if (ev.scl_rise && r_reg.bitcnt != dual_supply_pkg::BYTE_BITS)
        begin
          r_next.shift  = {r_reg.shift[6:0], ev.sda};
          r_next.bitcnt = r_reg.bitcnt + 4'h1;
        end else if (ev.scl_fall
                     && r_reg.bitcnt == dual_supply_pkg::BYTE_BITS) begin
          r_next.bitcnt = 4'h0;
          if (r_reg.uvlo_s2) begin
            r_next.st = dual_supply_pkg::ST_IGNORE;
          end else begin
            case (r_reg.phase)
              dual_supply_pkg::PH_CHIP: begin
                if (r_reg.shift[7:1] == r_reg.chip_s2) begin
                  r_next.rd = (r_reg.shift[0] ==
                               dual_supply_pkg::DIR_READ);
                  r_next.busy   = 1'b1;
                  r_next.sda_oe = 1'b1;
                  r_next.st     = dual_supply_pkg::ST_ACK;
                end else begin
                  r_next.st = dual_supply_pkg::ST_IGNORE;
                end
              end
              dual_supply_pkg::PH_REG: begin
                r_next.ptr    = r_reg.shift;
                r_next.sda_oe = 1'b1;
                r_next.st     = dual_supply_pkg::ST_ACK;
              end
              dual_supply_pkg::PH_DATA: begin
                // the stored byte is kept whole, reserved bits too
                if (r_reg.ptr == dual_supply_pkg::ADDR_VOLT_SEL) begin
                  r_next.volt_sel = r_reg.shift;
                end
                if (r_reg.ptr == dual_supply_pkg::ADDR_TONE_MODE) begin
                  r_next.tone_mode = r_reg.shift;
                end
                r_next.ptr    = next_ptr(r_reg.ptr);
                r_next.sda_oe = 1'b1;
                r_next.st     = dual_supply_pkg::ST_ACK;
              end
              default: begin
                r_next.st = dual_supply_pkg::ST_IGNORE;
              end
            endcase
          end
        end
      end

      // hold data low across the whole acknowledge pulse
      // released three clocks after the fall, well inside clock low
      dual_supply_pkg::ST_ACK: begin
        if (ev.scl_fall) begin
          r_next.bitcnt = 4'h0;
          if (r_reg.rd && r_reg.phase == dual_supply_pkg::PH_CHIP) begin
            r_next.shift = read_byte(r_reg.ptr, r_reg.volt_sel,
                                     r_reg.tone_mode);
            r_next.ptr    = next_ptr(r_reg.ptr);
            r_next.sda_oe = ~r_next.shift[7];
            r_next.st     = dual_supply_pkg::ST_TX;
          end else begin
            r_next.sda_oe = 1'b0;
            r_next.st     = dual_supply_pkg::ST_RX;
            r_next.phase  = (r_reg.phase == dual_supply_pkg::PH_CHIP)
                            ? dual_supply_pkg::PH_REG
                            : dual_supply_pkg::PH_DATA;
          end
        end
      end

      // shift a byte out, changing data only after a falling clock
      // the first bit was already placed when the acknowledge ended
      dual_supply_pkg::ST_TX: begin
        if (ev.scl_fall) begin
          if (r_reg.bitcnt == dual_supply_pkg::LAST_TX_BIT) begin
            r_next.sda_oe = 1'b0;
            r_next.st     = dual_supply_pkg::ST_MACK;
          end else begin
            r_next.shift  = {r_reg.shift[6:0], 1'b0};
            r_next.sda_oe = ~r_reg.shift[6];
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end
        end
      end

      // master acknowledge: low continues, high ends the read
      dual_supply_pkg::ST_MACK: begin
        if (ev.scl_rise) begin
          r_next.mack_high = ev.sda;
        end else if (ev.scl_fall) begin
          r_next.bitcnt = 4'h0;
          if (r_reg.mack_high) begin
            r_next.sda_oe = 1'b0;
            r_next.st     = dual_supply_pkg::ST_IGNORE;
          end else begin
            r_next.shift = read_byte(r_reg.ptr, r_reg.volt_sel,
                                     r_reg.tone_mode);
            r_next.ptr    = next_ptr(r_reg.ptr);
            r_next.sda_oe = ~r_next.shift[7];
            r_next.st     = dual_supply_pkg::ST_TX;
          end
        end
      end

      // not addressed or finished: wait for the next condition
      dual_supply_pkg::ST_IGNORE: begin
        r_next.sda_oe = 1'b0;
      end

      default: begin
        r_next.st     = dual_supply_pkg::ST_IDLE;
        r_next.sda_oe = 1'b0;
      end
    endcase

    // start and stop override any byte in progress
    // a repeated start is taken like a start after a stop
    if (ev.start) begin
      r_next.st        = dual_supply_pkg::ST_RX;
      r_next.phase     = dual_supply_pkg::PH_CHIP;
      r_next.bitcnt    = 4'h0;
      r_next.rd        = 1'b0;
      r_next.mack_high = 1'b0;
      r_next.sda_oe    = 1'b0;
      r_next.busy      = 1'b0;
    end else if (ev.stop) begin
      r_next.st     = dual_supply_pkg::ST_IDLE;
      r_next.sda_oe = 1'b0;
      r_next.busy   = 1'b0;
    end

    // tone pin gated by each channel's enable
    r_next.tone_gate[0] =
      tone_gated(r_next.tone_mode[dual_supply_pkg::TONE_ON_A_BIT],
                 r_reg.tin_s2[0]);
    r_next.tone_gate[1] =
      tone_gated(r_next.tone_mode[dual_supply_pkg::TONE_ON_B_BIT],
                 r_reg.tin_s2[1]);

    // low power never reaches the supply while a tone is enabled
    r_next.low_power[0] =
      low_power_gated(r_next.tone_mode[dual_supply_pkg::LOW_POWER_A_BIT],
                      r_next.tone_mode[dual_supply_pkg::TONE_ON_A_BIT]);
    r_next.low_power[1] =
      low_power_gated(r_next.tone_mode[dual_supply_pkg::LOW_POWER_B_BIT],
                      r_next.tone_mode[dual_supply_pkg::TONE_ON_B_BIT]);
  end

  // state register; clock enable freezes all of it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg <= CTL_RST;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  // open-drain data: only ever pulls low
  // a driven high would fight the pull-up and other targets
  assign sda_o    = 1'b0;
  assign sda_oe_o = r_reg.sda_oe;

  // register fields to the analog side; tone and low power bits come through their gates
  assign volt_sel_a_o = r_reg.volt_sel[dual_supply_pkg::VSEL_A_LSB
                                       +: dual_supply_pkg::VSEL_W];
  assign volt_sel_b_o = r_reg.volt_sel[dual_supply_pkg::VSEL_B_LSB
                                       +: dual_supply_pkg::VSEL_W];
  assign tone_gate_a_o = r_reg.tone_gate[0];
  assign tone_gate_b_o = r_reg.tone_gate[1];
  assign low_power_a_o = r_reg.low_power[0];
  assign low_power_b_o = r_reg.low_power[1];
  assign tone_input_kind_a_o =
    r_reg.tone_mode[dual_supply_pkg::KIND_A_BIT];
  assign tone_input_kind_b_o =
    r_reg.tone_mode[dual_supply_pkg::KIND_B_BIT];
  assign busy_o = r_reg.busy;

endmodule // dual_supply_ctrl

// ### verification/dual_supply_ctrl_properties.sv
// timing checks on the pins of the two-wire control target
// assumes one clock domain; bound onto every instance of the target
`timescale 1ns/100ps
module dual_supply_ctrl_properties (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       uvlo_i,
  input wire logic       tone_input_pin_b_i,
  input wire logic [3:0] volt_sel_a_o,
  input wire logic [3:0] volt_sel_b_o,
  input wire logic       tone_gate_a_o,
  input wire logic       tone_gate_b_o,
  input wire logic       low_power_a_o,
  input wire logic       low_power_b_o,
  input wire logic       tone_input_kind_a_o,
  input wire logic       tone_input_kind_b_o,
  input wire logic       busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // pin behaviour
  chk_sda_open: assert property (!sda_o)
    else $error("data pin driven high");
  chk_oe_busy: assert property (sda_oe_o |-> busy_o)
    else $error("data pulled while not addressed");
  chk_oe_clk_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data drive changed while clock high");
  chk_ack_hold: assert property ($rose(sda_oe_o) |-> sda_oe_o [*4])
    else $error("data pull dropped too soon");
  chk_stop_ends: assert property (
    scl_i && $rose(sda_i) |-> ##[1:8] !busy_o)
    else $error("stop did not end transfer");
  chk_uvlo_lock: assert property (uvlo_i [*8] |-> !$rose(busy_o))
    else $error("addressed during lockout");
  // register outputs
  chk_lp_excl_a: assert property (low_power_a_o |-> !tone_gate_a_o)
    else $error("low power a with tone");
  chk_lp_excl_b: assert property (low_power_b_o |-> !tone_gate_b_o)
    else $error("low power b with tone");
  chk_gate_pin_b: assert property (
    !tone_input_pin_b_i [*4] |-> !tone_gate_b_o)
    else $error("tone b not gated by pin");
  chk_sel_write: assert property (
    $changed({volt_sel_a_o, volt_sel_b_o}) |-> busy_o)
    else $error("voltage select changed outside write");
  chk_kind_write: assert property (
    $changed({tone_input_kind_a_o, tone_input_kind_b_o}) |-> busy_o)
    else $error("input kind changed outside write");

  // main scenarios
  cov_addressed: cover property ($rose(busy_o));
  cov_low_power: cover property (low_power_a_o && low_power_b_o);
  cov_stop_busy: cover property (scl_i && $rose(sda_i) && busy_o);
endmodule // dual_supply_ctrl_properties

bind dual_supply_ctrl dual_supply_ctrl_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .uvlo_i(uvlo_i),
  .tone_input_pin_b_i(tone_input_pin_b_i),
  .volt_sel_a_o(volt_sel_a_o), .volt_sel_b_o(volt_sel_b_o),
  .tone_gate_a_o(tone_gate_a_o), .tone_gate_b_o(tone_gate_b_o),
  .low_power_a_o(low_power_a_o), .low_power_b_o(low_power_b_o),
  .tone_input_kind_a_o(tone_input_kind_a_o),
  .tone_input_kind_b_o(tone_input_kind_b_o), .busy_o(busy_o));

// ### verification/bus_host_model.sv
// behavioural two-wire bus master driving clock and open-drain data
// assumes data line has a pull-up; 16 clk per bit, changes on clk rise
`timescale 1ns/100ps
module bus_host_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // idle bus: both lines released
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one bit: data set well inside clock low, sampled mid high
  task automatic bit_io(input logic d, output logic s);
    tick(2);
    sda_low_o <= !d;
    tick(6);
    scl_o <= 1'b1;
    tick(4);
    s = sda_i;
    tick(4);
    scl_o <= 1'b0;
  endtask

  task automatic start_c();
    tick(4);
    sda_low_o <= 1'b1;
    tick(8);
    scl_o <= 1'b0;
  endtask

  // stop closes every transfer before the next start
  task automatic stop_c();
    tick(2);
    sda_low_o <= 1'b1;
    tick(6);
    scl_o <= 1'b1;
    tick(8);
    sda_low_o <= 1'b0;
    tick(8);
  endtask

  // eight bits msb first, then release for the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask

  // low acknowledge asks for more, high ends the read
  task automatic recv_byte(output logic [7:0] b, input logic more);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(!more, s);
  endtask
endmodule // bus_host_model

// ### verification/dual_supply_i2c_control_tb.sv
// self-checking bench for the two-wire control target
// assumes bus_host_model as master and a pull-up on the data line
`timescale 1ns/100ps
module dual_supply_i2c_control_tb;
  localparam logic [6:0] CHIP = 7'h10;
  logic       clk, rst, uvlo, pin_a, pin_b, ce;
  logic [7:0] st1, st2;
  logic       scl, sda_low, sda_o, sda_oe, kind_a, kind_b, busy;
  logic       gate_a, gate_b, lp_a, lp_b;
  logic [3:0] vsel_a, vsel_b;
  int         errors, check_count, cycles;
  wire        sda = !((sda_oe && !sda_o) || sda_low);

  dual_supply_ctrl dut (
    .clk_i(clk), .rst_i(rst), .ce_i(ce), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .chip_addr_i(CHIP),
    .uvlo_i(uvlo), .tone_input_pin_a_i(pin_a),
    .tone_input_pin_b_i(pin_b), .status1_i(st1), .status2_i(st2),
    .volt_sel_a_o(vsel_a), .volt_sel_b_o(vsel_b),
    .tone_gate_a_o(gate_a), .tone_gate_b_o(gate_b),
    .low_power_a_o(lp_a), .low_power_b_o(lp_b),
    .tone_input_kind_a_o(kind_a), .tone_input_kind_b_o(kind_b),
    .busy_o(busy));
  bus_host_model host (.clk_i(clk), .sda_i(sda), .scl_o(scl),
                       .sda_low_o(sda_low));

  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] flags();
    return {2'b00, gate_b, gate_a, lp_b, lp_a, kind_b, kind_a};
  endfunction

  // bus cycle helpers
  task automatic open_xfer(input logic [6:0] c, input logic rd,
                           input logic exp_ack);
    logic a;
    host.start_c();
    host.send_byte({c, rd}, a);
    check({7'h00, a}, {7'h00, exp_ack});
  endtask
  task automatic put(input logic [7:0] b);
    logic a;
    host.send_byte(b, a);
    check({7'h00, a}, 8'h01);
  endtask
  task automatic get(input logic [7:0] exp, input logic more);
    logic [7:0] b;
    host.recv_byte(b, more);
    check(b, exp);
  endtask
  task automatic set_ptr(input logic [7:0] r);
    open_xfer(CHIP, 1'b0, 1'b1);
    put(r);
    host.stop_c();
  endtask

  // scenarios
  task automatic t_write_auto();
    open_xfer(CHIP, 1'b0, 1'b1);
    put(dual_supply_pkg::ADDR_VOLT_SEL);
    put(8'h5a);
    put(8'h15);
    host.stop_c();
    check({vsel_b, vsel_a}, 8'h5a);
    check(flags(), 8'h11);
    pin_b <= 1'b1;
    host.tick(8);
    check(flags(), 8'h31);
    pin_b <= 1'b0;
    host.tick(8);
    check(flags(), 8'h11);
    ce <= 1'b0;
    pin_a <= 1'b0;
    host.tick(8);
    check(flags(), 8'h11);
    ce <= 1'b1;
    host.tick(8);
    check(flags(), 8'h01);
    pin_a <= 1'b1;
    host.tick(8);
    $display("test write_auto done");
  endtask

  task automatic t_read_back();
    set_ptr(dual_supply_pkg::ADDR_VOLT_SEL);
    open_xfer(CHIP, 1'b1, 1'b1);
    get(8'h5a, 1'b1);
    get(8'h15, 1'b0);
    host.stop_c();
    check({6'h00, busy, sda_oe}, 8'h00);
    $display("test read_back done");
  endtask

  task automatic t_modes_partial();
    open_xfer(CHIP, 1'b0, 1'b1);
    put(dual_supply_pkg::ADDR_TONE_MODE);
    put(8'h62);
    host.stop_c();
    check(flags(), 8'h0e);
    check({vsel_b, vsel_a}, 8'h5a);
    set_ptr(dual_supply_pkg::ADDR_TONE_MODE);
    open_xfer(CHIP, 1'b1, 1'b1);
    get(8'h62, 1'b0);
    host.stop_c();
    $display("test modes_partial done");
  endtask

  task automatic t_status_scan();
    set_ptr(dual_supply_pkg::ADDR_STATUS1);
    open_xfer(CHIP, 1'b1, 1'b1);
    get(8'ha5, 1'b1);
    get(8'h3c, 1'b1);
    get(8'h5a, 1'b1);
    get(8'h62, 1'b1);
    get(dual_supply_pkg::UNMAPPED_READ, 1'b0);
    host.stop_c();
    $display("test status_scan done");
  endtask

  task automatic t_foreign();
    logic a;
    open_xfer(CHIP ^ 7'h01, 1'b0, 1'b0);
    host.send_byte(dual_supply_pkg::ADDR_VOLT_SEL, a);
    host.send_byte(8'hff, a);
    host.stop_c();
    check({vsel_b, vsel_a}, 8'h5a);
    $display("test foreign done");
  endtask

  task automatic t_lockout();
    uvlo <= 1'b1;
    host.tick(8);
    open_xfer(CHIP, 1'b0, 1'b0);
    host.stop_c();
    uvlo <= 1'b0;
    host.tick(8);
    open_xfer(CHIP, 1'b0, 1'b1);
    put(dual_supply_pkg::ADDR_VOLT_SEL);
    put(8'h00);
    host.stop_c();
    check({vsel_b, vsel_a}, 8'h00);
    $display("test lockout done");
  endtask

  // reset, then the scenarios in order
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    uvlo = 1'b0;
    pin_a = 1'b1;
    pin_b = 1'b0;
    st1 = 8'ha5;
    st2 = 8'h3c;
    errors = 0;
    check_count = 0;
    cycles = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    host.tick(8);
    t_write_auto();
    t_read_back();
    t_modes_partial();
    t_status_scan();
    t_foreign();
    t_lockout();
    final_report();
  end
endmodule // dual_supply_i2c_control_tb
